// file: logic/rxm_output_mute.sv
// rxm_output_mute: receive-side recovery select, lock detect, output mute.
// assumes all pins and the line clock are asynchronous to clk; data from
// the deserialiser changes only on the rising edge of lineClock.
`timescale 1ns/10ps

// Behaviour
// R1 - low reference select locks to training clock; high follows line data
// R2 - hardware mode: low data disable forces all data outputs to zero
// R3 - host mode: shared pin shows analyser lock while generator enabled
// R4 - low clock disable holds the parallel clock output at zero
// R5 - lock detect output high while recovery locked, low otherwise
// R6 - inactive optical signal detect mutes the parallel data bus
// R7 - polarity input selects active level of optical signal detect
// R8 - control pins idle high when open: normal, enabled, signal present
// R9 - mode select low is hardware mode, high is host; defaults to hardware
// R10 - data outputs change together on clock output fall, first bit on MSB
// R11 - data muted when data disable or loss of signal holds, combined by OR
module rxm_output_mute
    import rxm_pkg::*;
#(
    parameter int DATA_W = RXM_DATA_W,
    parameter int LOCK_PERIODS = RXM_LOCK_PERIODS
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // recovered line clock and deserialised word, MSB is first bit
    input wire logic lineClock,
    input wire logic [DATA_W-1:0] lineData,
    // static control pins
    input wire rxm_ctrl_t ctrlPins,
    // shared data disable / analyser lock pin
    input wire logic dataPinIn,
    output logic dataPinOut,
    output logic dataPinOen_n,
    // pattern generator and analyser status
    input wire logic patternGeneratorEnable,
    input wire logic patternAnalyserLock,
    // parallel receive outputs
    output logic [DATA_W-1:0] rxParallelDataOut,
    output logic rxParallelClockOut,
    // status
    output logic recoveryLockDetect,
    output logic lossOfSignalDetect
);

    localparam logic [RXM_CNT_W-1:0] NOM_CNT = RXM_CNT_W'(RXM_NOM_CYC);
    localparam logic [RXM_CNT_W-1:0] TOL_CNT = RXM_CNT_W'(RXM_TOL_CYC);
    localparam logic [RXM_CNT_W-1:0] MIN_CNT = NOM_CNT - TOL_CNT;
    localparam logic [RXM_CNT_W-1:0] MAX_CNT = NOM_CNT + TOL_CNT;
    localparam logic [RXM_CNT_W-1:0] CNT_ONE = RXM_CNT_W'(1);
    localparam logic [RXM_GOOD_W-1:0] GOOD_DONE =
        RXM_GOOD_W'(LOCK_PERIODS - 1);
    localparam logic [RXM_GOOD_W-1:0] GOOD_ONE = RXM_GOOD_W'(1);
    localparam logic [RXM_DIV_W-1:0] DIV_LAST = RXM_DIV_W'(RXM_HALF_CYC - 1);
    localparam logic [RXM_DIV_W-1:0] DIV_ONE = RXM_DIV_W'(1);

    // synchroniser stages
    rxm_ctrl_t ctrlMeta_r;
    rxm_ctrl_t ctrl_r;
    logic disMeta_r;
    logic dis_r;
    logic lockMeta_r;
    logic lock_r;
    logic genMeta_r;
    logic gen_r;
    logic lineMeta_r;
    logic line_r;
    logic [DATA_W-1:0] wordMeta_r;
    logic [DATA_W-1:0] word_r;

    // recovery and detector state
    logic trainClk_r;
    logic [RXM_DIV_W-1:0] trainDiv_r;
    logic srcLevel;
    logic srcPrev_r;
    logic srcRise;
    logic srcFall;
    logic refSelPrev_r;
    logic [RXM_CNT_W-1:0] periodCnt_r;
    logic [RXM_GOOD_W-1:0] goodCnt_r;
    logic periodOk;
    rxm_lock_t lockState_r;
    rxm_lock_t lockState_nxt;

    // mute terms
    logic hostMode;
    logic signalPresent;
    logic dataMute;

    // two-stage synchronisers; reset levels mirror pin pulls
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrlMeta_r <= RXM_CTRL_RST; // [R8] [R9]
            ctrl_r <= RXM_CTRL_RST; // [R8] [R9]
            disMeta_r <= RXM_PULLUP_LVL; // [R8]
            dis_r <= RXM_PULLUP_LVL; // [R8]
            lockMeta_r <= 1'b0;
            lock_r <= 1'b0;
            genMeta_r <= 1'b0;
            gen_r <= 1'b0;
            lineMeta_r <= 1'b0;
            line_r <= 1'b0;
            wordMeta_r <= '0;
            word_r <= '0;
        end
        else
        begin
            ctrlMeta_r <= ctrlPins;
            ctrl_r <= ctrlMeta_r;
            disMeta_r <= dataPinIn;
            dis_r <= disMeta_r;
            lockMeta_r <= patternAnalyserLock;
            lock_r <= lockMeta_r;
            genMeta_r <= patternGeneratorEnable;
            gen_r <= genMeta_r;
            lineMeta_r <= lineClock;
            line_r <= lineMeta_r;
            wordMeta_r <= lineData; // word lags the clock by the same two flops
            word_r <= wordMeta_r;
        end
    end

    // training reference: clk divided to the nominal line period
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            trainDiv_r <= '0;
            trainClk_r <= 1'b0;
        end
        else if (trainDiv_r == DIV_LAST)
        begin
            trainDiv_r <= '0;
            trainClk_r <= ~trainClk_r;
        end
        else
        begin
            trainDiv_r <= trainDiv_r + DIV_ONE;
        end
    end

    // source of the recovered clock
    assign srcLevel = ctrl_r.recoveryReferenceSelectN ? line_r
                      : trainClk_r; // [R1]
    assign srcRise = srcLevel && !srcPrev_r;
    assign srcFall = !srcLevel && srcPrev_r;

    // edge history and reference-select history
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            srcPrev_r <= 1'b0;
            refSelPrev_r <= RXM_PULLUP_LVL;
        end
        else
        begin
            srcPrev_r <= srcLevel;
            refSelPrev_r <= ctrl_r.recoveryReferenceSelectN;
        end
    end

    // cycles since last rising edge, saturating past the window
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            periodCnt_r <= '0;
        else if (srcRise)
            periodCnt_r <= CNT_ONE;
        else if (periodCnt_r <= MAX_CNT)
            periodCnt_r <= periodCnt_r + CNT_ONE;
    end

    assign periodOk = (periodCnt_r >= MIN_CNT) && (periodCnt_r <= MAX_CNT);

    // count of good periods in a row
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            goodCnt_r <= '0;
        else if (lockState_nxt != RXM_CHECK)
            goodCnt_r <= '0;
        else if (srcRise && lockState_r == RXM_CHECK)
            goodCnt_r <= goodCnt_r + GOOD_ONE; // first rise only opens a period
    end

    // lock detector next state
    always_comb
    begin
        lockState_nxt = lockState_r;
        if (ctrl_r.recoveryReferenceSelectN != refSelPrev_r)
            lockState_nxt = RXM_HUNT; // [R1]
        else if (periodCnt_r > MAX_CNT)
            lockState_nxt = RXM_HUNT; // [R5]
        else
        begin
            unique case (lockState_r)
                RXM_HUNT:
                    if (srcRise)
                        lockState_nxt = RXM_CHECK;
                RXM_CHECK:
                    if (srcRise && !periodOk)
                        lockState_nxt = RXM_HUNT;
                    else if (srcRise && goodCnt_r == GOOD_DONE)
                        lockState_nxt = RXM_LOCKED; // [R5]
                RXM_LOCKED:
                    if (srcRise && !periodOk)
                        lockState_nxt = RXM_HUNT; // [R5]
                default:
                    lockState_nxt = RXM_HUNT;
            endcase
        end
    end

    // lock state and lock detect output
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lockState_r <= RXM_HUNT;
            recoveryLockDetect <= 1'b0;
        end
        else
        begin
            lockState_r <= lockState_nxt;
            recoveryLockDetect <= (lockState_nxt == RXM_LOCKED); // [R5]
        end
    end

    // mute causes
    assign hostMode = ctrl_r.hostHardwareSelect; // [R9]
    assign signalPresent = (ctrl_r.opticalSignalDetect ==
                            ctrl_r.signalDetectPolarity); // [R7]
    assign dataMute = (!hostMode && !dis_r) // [R2]
                      || !signalPresent; // [R6] [R11]

    // parallel clock output, held low while disabled
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rxParallelClockOut <= 1'b0;
        else
            rxParallelClockOut <= srcLevel && ctrl_r.rxClockDisableN; // [R4]
    end

    // data word: loaded on clock fall, forced to zero at once on mute
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rxParallelDataOut <= '0;
        else if (dataMute)
            rxParallelDataOut <= '0; // [R2] [R6] [R11]
        else if (srcFall)
            rxParallelDataOut <= word_r; // [R10]
    end

    // loss-of-signal status
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            lossOfSignalDetect <= 1'b0;
        else
            lossOfSignalDetect <= !signalPresent; // [R6]
    end

    // shared pin: input in hardware mode, analyser lock out in host mode
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dataPinOut <= 1'b0;
            dataPinOen_n <= 1'b1;
        end
        else
        begin
            dataPinOut <= hostMode && gen_r && lock_r; // [R3]
            dataPinOen_n <= !hostMode; // [R3] [R9]
        end
    end

endmodule // rxm_output_mute

// file: logic/rxm_pkg.sv
// rxm_pkg: constants and types for the receive output mute control block.
// assumes a 25 MHz system clock and a recovered parallel clock near 3.125 MHz.
package rxm_pkg;

    // data bus width
    localparam int RXM_DATA_W = 16;

    // clock timing, in nanoseconds as specified
    localparam int RXM_CLK_PERIOD_NS = 40;
    localparam int RXM_LINE_PERIOD_NS = 320;
    localparam int RXM_TOL_NS = 40;

    // derived cycle counts: nominal period, tolerance rounded down
    localparam int RXM_NOM_CYC = RXM_LINE_PERIOD_NS / RXM_CLK_PERIOD_NS;
    localparam int RXM_TOL_CYC_RAW = RXM_TOL_NS / RXM_CLK_PERIOD_NS;
    localparam int RXM_TOL_CYC = (RXM_TOL_CYC_RAW < 1) ? 1 : RXM_TOL_CYC_RAW;
    localparam int RXM_HALF_CYC = RXM_NOM_CYC / 2;

    // good periods in a row before lock is declared
    localparam int RXM_LOCK_PERIODS = 4;

    // counter widths
    localparam int RXM_CNT_W = 5;
    localparam int RXM_GOOD_W = 3;
    localparam int RXM_DIV_W = 3;

    // reset levels of the synchronisers: pulled-up pins idle high
    localparam logic RXM_PULLUP_LVL = 1'b1;
    localparam logic RXM_PULLDN_LVL = 1'b0;

    // static or slow control pins, carried together
    typedef struct packed {
        logic recoveryReferenceSelectN; // low = training reference
        logic rxClockDisableN;          // low = parallel clock held low
        logic opticalSignalDetect;      // from the optical module
        logic signalDetectPolarity;     // active level of signal detect
        logic hostHardwareSelect;       // low = hardware, high = host
    } rxm_ctrl_t;

    // reset value of the control synchronisers
    localparam rxm_ctrl_t RXM_CTRL_RST = '{
        recoveryReferenceSelectN: RXM_PULLUP_LVL,
        rxClockDisableN: RXM_PULLUP_LVL,
        opticalSignalDetect: RXM_PULLUP_LVL,
        signalDetectPolarity: RXM_PULLUP_LVL,
        hostHardwareSelect: RXM_PULLDN_LVL
    };

    // lock detector states, gray coded along hunt -> check -> locked
    typedef enum logic [1:0] {
        RXM_HUNT = 2'b00,
        RXM_CHECK = 2'b01,
        RXM_LOCKED = 2'b11
    } rxm_lock_t;

endpackage

// file: verification/rxm_output_mute_assertions.sv
// rxm_output_mute_assertions: port checks for rxm_output_mute.
// assumes three clk edges from a pin change to the outputs.
`timescale 1ns/10ps
module rxm_output_mute_assertions
    import rxm_pkg::*;
#(
    parameter int DATA_W = RXM_DATA_W
)
(
    // clock, reset and inputs
    input wire logic clk,
    input wire logic nrst,
    input wire logic lineClock,
    input wire rxm_ctrl_t ctrlPins,
    input wire logic dataPinIn,
    input wire logic patternGeneratorEnable,
    input wire logic patternAnalyserLock,
    // outputs
    input wire logic dataPinOut,
    input wire logic dataPinOen_n,
    input wire logic [DATA_W-1:0] rxParallelDataOut,
    input wire logic rxParallelClockOut,
    input wire logic recoveryLockDetect,
    input wire logic lossOfSignalDetect
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // pin shorthands
    wire logic hwMode = !ctrlPins.hostHardwareSelect;
    wire logic sigOk = ctrlPins.opticalSignalDetect
        == ctrlPins.signalDetectPolarity;
    wire logic lineSel = ctrlPins.recoveryReferenceSelectN;
    property p_data_mute;
        (hwMode && !dataPinIn)[*4] |=> rxParallelDataOut == '0;
    endproperty
    a_data_mute: assert property (p_data_mute)
        else $error("disable pin did not mute");
    property p_los;
        !sigOk[*4] |=> lossOfSignalDetect && rxParallelDataOut == '0;
    endproperty
    a_los: assert property (p_los)
        else $error("loss of signal not muting");
    property p_no_los;
        sigOk[*4] |=> !lossOfSignalDetect;
    endproperty
    a_no_los: assert property (p_no_los)
        else $error("loss flag with signal present");
    property p_clk_gate;
        !ctrlPins.rxClockDisableN[*4] |=> !rxParallelClockOut;
    endproperty
    a_clk_gate: assert property (p_clk_gate)
        else $error("clock out not held low");
    property p_lock_out;
        (!hwMode && patternGeneratorEnable && patternAnalyserLock)[*4]
            |=> dataPinOut && !dataPinOen_n;
    endproperty
    a_lock_out: assert property (p_lock_out)
        else $error("analyser lock not driven");
    property p_hw_oen;
        hwMode[*4] |=> dataPinOen_n;
    endproperty
    a_hw_oen: assert property (p_hw_oen)
        else $error("pin driven in hardware mode");
    property p_lock_loss;
        (lineSel && $stable(lineClock))[*8] ##1
            (lineSel && $stable(lineClock))[*8] |=> !recoveryLockDetect;
    endproperty
    a_lock_loss: assert property (p_lock_loss)
        else $error("lock held without line clock");
    property p_data_edge;
        $changed(rxParallelDataOut) && rxParallelDataOut != '0
            |-> !rxParallelClockOut;
    endproperty
    a_data_edge: assert property (p_data_edge)
        else $error("data changed outside clock fall");
    // main scenarios
    c_lock: cover property ($rose(recoveryLockDetect));
    c_los: cover property (lossOfSignalDetect);
    c_host: cover property (dataPinOut);
endmodule // rxm_output_mute_assertions

bind rxm_output_mute rxm_output_mute_assertions #(.DATA_W(DATA_W)) chk_u (
    .clk(clk), .nrst(nrst), .lineClock(lineClock), .ctrlPins(ctrlPins),
    .dataPinIn(dataPinIn), .patternGeneratorEnable(patternGeneratorEnable),
    .patternAnalyserLock(patternAnalyserLock), .dataPinOut(dataPinOut),
    .dataPinOen_n(dataPinOen_n), .rxParallelDataOut(rxParallelDataOut),
    .rxParallelClockOut(rxParallelClockOut),
    .recoveryLockDetect(recoveryLockDetect),
    .lossOfSignalDetect(lossOfSignalDetect));

// file: verification/rxm_line_src.sv
// rxm_line_src: deserialiser model giving line clock and words.
// assumes the bench raises run to let the clock toggle.
`timescale 1ns/10ps
module rxm_line_src
    import rxm_pkg::*;
(
    // control and line side
    input wire logic run,
    output logic lineClock,
    output logic [RXM_DATA_W-1:0] lineData
);
    logic [7:0] wordCnt;
    // clock stands still when stopped; new word just after each rise
    initial
    begin
        lineClock = 1'b0;
        lineData = 16'h0000;
        wordCnt = 8'h00;
        #7;
        forever
        begin
            #(RXM_LINE_PERIOD_NS / 2);
            if (run)
            begin
                lineClock = ~lineClock;
                wordCnt = wordCnt + {7'h00, lineClock};
                lineData = {wordCnt, ~wordCnt};
            end
        end
    end
endmodule // rxm_line_src

// file: verification/tb.sv
// tb: self-checking bench for rxm_output_mute.
// assumes 40 ns clk and the line source model on the far side.
`timescale 1ns/10ps
module tb
    import rxm_pkg::*;
;
    logic clk, nrst, run, pinDrv, genEn, anLock, pinIn, pinOut, pinOen_n;
    logic lineClock, rxClk, lockDet, losDet;
    logic [RXM_DATA_W-1:0] lineData, rxData;
    rxm_ctrl_t ctrlPins;
    int mismatches, samples_checked;
    // shared pin: bench drives it unless the DUT output is enabled
    assign pinIn = pinOen_n ? pinDrv : pinOut;
    rxm_line_src src_u (.run(run), .lineClock(lineClock),
        .lineData(lineData));
    rxm_output_mute dut_u (.clk(clk), .nrst(nrst), .lineClock(lineClock),
        .lineData(lineData), .ctrlPins(ctrlPins), .dataPinIn(pinIn),
        .dataPinOut(pinOut), .dataPinOen_n(pinOen_n),
        .patternGeneratorEnable(genEn), .patternAnalyserLock(anLock),
        .rxParallelDataOut(rxData), .rxParallelClockOut(rxClk),
        .recoveryLockDetect(lockDet), .lossOfSignalDetect(losDet));
    // clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // word latched at the clock output fall
    task automatic word_chk();
        @(negedge rxClk);
        #1;
        chk("word", rxData, lineData);
    endtask
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // main sequence
    initial
    begin
        {nrst, run, genEn, anLock} = 4'h0;
        pinDrv = 1'b1;
        ctrlPins = 5'b11110;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        run <= 1'b1;
        wt(3);
        chk("oen", pinOen_n, 1);
        chk("los", losDet, 0);
        wt(80);
        chk("lock", lockDet, 1);
        repeat (3) word_chk();
        @(posedge clk);
        run <= 1'b0;
        wt(20);
        chk("lock", lockDet, 0);
        @(posedge clk);
        ctrlPins.recoveryReferenceSelectN <= 1'b0;
        wt(80);
        chk("lock", lockDet, 1);
        @(posedge clk);
        ctrlPins.recoveryReferenceSelectN <= 1'b1;
        run <= 1'b1;
        pinDrv <= 1'b0;
        wt(5);
        chk("mute", rxData, 0);
        @(posedge clk);
        pinDrv <= 1'b1;
        wt(4);
        word_chk();
        @(posedge clk);
        ctrlPins.rxClockDisableN <= 1'b0;
        wt(4);
        repeat (12)
        begin
            wt(1);
            chk("pclk", rxClk, 0);
        end
        @(posedge clk);
        ctrlPins.rxClockDisableN <= 1'b1;
        for (int p = 0; p < 2; p++)
            for (int s = 0; s < 2; s++)
            begin
                @(posedge clk);
                ctrlPins.signalDetectPolarity <= p[0];
                ctrlPins.opticalSignalDetect <= s[0];
                wt(12);
                chk("los", losDet, p != s);
                chk("mute", rxData == 0, p != s);
            end
        word_chk();
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk);
            ctrlPins.hostHardwareSelect <= 1'b1;
            genEn <= (i != 2);
            anLock <= (i != 1);
            wt(5);
            chk("oen", pinOen_n, 0);
            chk("plock", pinOut, i == 0);
        end
        results();
    end
    // watchdog
    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        results();
    end
endmodule // tb
